/* File: verif/sac_adc_ctrl_tb.sv */
/*
  self-checking bench for the converter control block.
  assumes zero-wait apb and the analog model as comparator.
*/
`default_nettype none
module sac_adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic pin = 1'b0, tmr = 1'b0, dz = 1'b0, d1 = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic pready, pslverr, er, above, rf4, rf5, sv;
  logic [15:0] sw, e16;
  sac_pkg::sac_afe_t afe;
  int n_fail = 0, n_tests = 0, n;
  int dv[4] = '{8, 4, 16, 32};
  sac_adc_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_convert_start_pin(pin), .i_timer2_trigger(tmr),
    .i_analog_output_zero_en(dz), .i_analog_output_one_en(d1), .i_cmp_above(above), .o_afe(afe),
    .o_dac_route_four(rf4), .o_dac_route_five(rf5), .o_spi_word(sw), .o_spi_valid(sv));
  sac_analog_model ana_u (.i_afe(afe), .i_route_four(rf4), .i_route_five(rf5), .o_above(above));
  always #2.5 i_sys_clk = ~i_sys_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    // the slave sets the pace; pready ends this wait, and if it never comes only the watchdog does
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // waits for the result pulse; n is the cycle count it took
  task wspi;
    n = 0;
    do begin @(posedge i_sys_clk); n++; end while (sv !== 1'b1 && n < 3000);
    chk_rng(n, 1, 2999);
  endtask
  function logic [15:0] ex(input logic [3:0] c);
    ex = {c, c, 4'h6, c ^ 4'h9};
  endfunction
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rdc(12'h000, 32'h0);
    rdc(12'h014, 32'h800);
    rdc(12'h018, 32'h800);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    done("reset");
    apb(1'b1, 12'h000, 32'h10);
    for (int c = 0; c < 11; c++) begin
      apb(1'b1, 12'h004, 32'hA0 | c);
      // busy shows one cycle after the start
      @(posedge i_sys_clk);
      rdc(12'h008, 32'h80);
      wspi;
      e16 = ex(4'(c));
      chk(sw, e16);
      rdc(12'h00C, {24'h0, e16[7:0]});
      rdc(12'h010, {24'h0, e16[15:8]});
      rdc(12'h004, 32'h80 | c);
    end
    done("channels");
    dz <= 1'b1;
    d1 <= 1'b1;
    for (int c = 4; c < 6; c++) begin
      apb(1'b1, 12'h004, 32'hA0 | c);
      wspi;
      chk(sw, {4'(c), (c == 4) ? 12'hD21 : 12'h3EC});
    end
    dz <= 1'b0;
    d1 <= 1'b0;
    done("dac");
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 12'h000, 32'(d * 20));
      apb(1'b1, 12'h004, 32'hA1);
      wspi;
      chk_rng(n, (d + 13) * dv[d] + 2, (d + 13) * dv[d] + 2);
    end
    done("timing");
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h004, 32'h92);
    repeat (3) begin
      wspi;
      chk(sw, ex(4'h2));
      chk_rng(n, 1, 70);
    end
    apb(1'b1, 12'h004, 32'h00);
    repeat (100) @(posedge i_sys_clk);
    rdc(12'h008, 32'h0);
    done("continuous");
    apb(1'b1, 12'h004, 32'h81);
    apb(1'b1, 12'h000, 32'h12);
    pin <= 1'b1;
    @(posedge i_sys_clk);
    pin <= 1'b0;
    wspi;
    chk(sw, ex(4'h1));
    apb(1'b1, 12'h000, 32'h11);
    repeat (2) begin
      tmr <= 1'b1;
      @(posedge i_sys_clk);
      tmr <= 1'b0;
      wspi;
      chk(sw, ex(4'h1));
    end
    done("triggers");
    apb(1'b1, 12'h000, 32'h50);
    repeat (2) @(posedge i_sys_clk);
    chk({31'h0, afe.ext_ref}, 32'h1);
    done("reference");
    apb(1'b1, 12'h008, 32'h01);
    @(posedge i_sys_clk);
    rdc(12'h008, 32'h81);
    repeat (200) @(posedge i_sys_clk);
    rdc(12'h008, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, r != 32'h800}, 32'h1);
    rdc(12'h018, 32'h800);
    done("calibration");
    apb(1'b1, 12'h004, 32'hA3);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rdc(12'h008, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h014, 32'h800);
    done("second reset");
    stop_test;
  end
endmodule
bind sac_adc_ctrl sac_props chk_u (.i_sys_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_pready, .i_analog_output_zero_en, .i_analog_output_one_en, .o_afe, .o_dac_route_four,
  .o_dac_route_five, .o_spi_word, .o_spi_valid);
`default_nettype wire

/* File: verif/sac_analog_model.sv */
/*
  analog sources and comparator seen by the converter control block.
  assumes the design presents channel and trial code on its afe port.
*/
`default_nettype none
module sac_analog_model (
  // afe control and dac routing from the design
  input wire sac_pkg::sac_afe_t i_afe,
  input wire logic i_route_four,
  input wire logic i_route_five,
  // comparator answer
  output logic o_above
);
  logic [11:0] level;
  // each channel holds its own fixed level, so a wrong mux choice shows
  always_comb begin
    level = {i_afe.chan, 4'h6, i_afe.chan ^ 4'h9};
    if (i_route_four) level = 12'hD21;
    if (i_route_five) level = 12'h3EC;
    o_above = (level >= i_afe.trial);
  end
endmodule
`default_nettype wire

/* File: verif/sac_props.sv */
/*
  port checker for the converter control block.
  assumes it is bound to sac_adc_ctrl from the bench top.
*/
`default_nettype none
module sac_props (
  // clock, reset and apb
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  // dac, afe and spi path
  input wire logic i_analog_output_zero_en,
  input wire logic i_analog_output_one_en,
  input wire sac_pkg::sac_afe_t o_afe,
  input wire logic o_dac_route_four,
  input wire logic o_dac_route_five,
  input wire logic [15:0] o_spi_word,
  input wire logic o_spi_valid
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire logic ref_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h000 && i_pwdata[6];
  chk_spi_pulse: assert property (o_spi_valid |=> !o_spi_valid)
    else $error("spi valid held too long");
  chk_spi_chan: assert property (o_spi_valid |-> o_spi_word[15:12] == o_afe.chan)
    else $error("spi word channel mismatch");
  chk_route_four: assert property (o_dac_route_four |-> $past(i_analog_output_zero_en) && o_afe.chan == 4'h4)
    else $error("channel four routed wrongly");
  chk_route_five: assert property (o_dac_route_five |-> $past(i_analog_output_one_en) && o_afe.chan == 4'h5)
    else $error("channel five routed wrongly");
  chk_ext_ref: assert property ($rose(o_afe.ext_ref) |-> $past(ref_wr, 1) || $past(ref_wr, 2))
    else $error("external reference without write");
  chk_sample_len: assert property ($rose(o_afe.sample) |-> o_afe.sample [*4])
    else $error("acquisition shorter than one tick");
  chk_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  chk_pready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("pready without setup cycle");
endmodule
`default_nettype wire

/* File: verilog/sac_adc_ctrl.sv */
/*
  control, trigger, calibration and result logic around a 12-bit sar
  converter, with an apb slave for its registers.
  assumes the analog comparator answers within one converter clock and that
  the timer trigger and convert pin are synchronous to i_sys_clk.
*/
// Design decisions made here: the APB register port and the register addresses.
`include "sac_regs.svh"
`default_nettype none
module sac_adc_ctrl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // triggers
  input wire logic i_convert_start_pin,
  input wire logic i_timer2_trigger,
  // dac enables, channels four and five share their pins
  input wire logic i_analog_output_zero_en,
  input wire logic i_analog_output_one_en,
  // comparator: high when the input is above the trial level
  input wire logic i_cmp_above,
  // analog front end control
  output sac_pkg::sac_afe_t o_afe,
  output logic o_dac_route_four,
  output logic o_dac_route_five,
  // capture path toward the spi port
  output logic [15:0] o_spi_word,
  output logic o_spi_valid
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] ctrl3_q;
  logic [3:0] chan_q;
  logic [7:0] res_lo_q;
  logic [7:0] res_hi_q;
  logic [11:0] offset_q;
  logic [11:0] gain_q;
  logic busy_q;
  sac_pkg::sac_state_t state_q;
  logic [4:0] div_cnt_q;
  logic tick;
  logic [1:0] acq_cnt_q;
  logic [3:0] bit_q;
  logic [11:0] sar_q;
  logic [4:0] cal_cnt_q;
  logic [11:0] cal_acc_q;
  logic conv_done;
  logic cal_done;
  logic wr_en;
  logic rd_en;
  logic [11:0] corrected;
  logic start_req;
  logic div_sync;
  logic conv_start;
  logic [11:0] final_code;
  sac_pkg::sac_result_t res_d;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  function automatic logic [4:0] div_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: div_ratio = 5'h07;
      2'h1: div_ratio = 5'h03;
      2'h2: div_ratio = 5'h0F;
      default: div_ratio = 5'h1F;
    endcase
  endfunction

  // write strobe for one register word
  function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] off, input logic wr);
    wr_hit = wr && (addr == off);
  endfunction

  // ----------------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------------
  // a tick every 8/4/16/32 core clocks; a new ratio takes effect at wrap
  // a start realigns the count so no partial converter clock is lost
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt_q <= 5'h00;
    end else if ((div_cnt_q == 5'h00) || div_sync) begin
      div_cnt_q <= div_ratio(ctrl1_q[`SAC_C1_CLKDIV_HI:`SAC_C1_CLKDIV_LO]);
    end else begin
      div_cnt_q <= div_cnt_q - 5'h01;
    end
  end
  assign tick = (div_cnt_q == 5'h00);

  // ----------------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------------
  assign start_req = ctrl2_q[`SAC_C2_SINGLE] || ctrl2_q[`SAC_C2_CONT]
    || (ctrl1_q[`SAC_C1_EXTTRIG] && i_convert_start_pin)
    || (ctrl1_q[`SAC_C1_TMRTRIG] && i_timer2_trigger);
  // leaving idle restarts the divider, so acquisition spans whole converter clocks
  assign div_sync = (state_q == sac_pkg::SAC_IDLE) && (ctrl3_q[`SAC_C3_START_CALIBRATION_BIT] || start_req);
  // calibration has priority, so a pending single start waits for it
  assign conv_start = (state_q == sac_pkg::SAC_IDLE) && !ctrl3_q[`SAC_C3_START_CALIBRATION_BIT] && start_req;

  assign conv_done = (state_q == sac_pkg::SAC_CONV) && tick && (bit_q == 4'h0);
  assign cal_done = (state_q == sac_pkg::SAC_CAL) && tick && (cal_cnt_q == 5'h00);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= sac_pkg::SAC_LOAD;
      acq_cnt_q <= 2'h0;
      bit_q <= 4'h0;
      sar_q <= 12'h000;
      cal_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        sac_pkg::SAC_LOAD: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_IDLE: begin
          if (ctrl3_q[`SAC_C3_START_CALIBRATION_BIT]) begin
            state_q <= sac_pkg::SAC_CAL;
            cal_cnt_q <= `SAC_CAL_STEPS - 5'h01;
          end else if (start_req) begin
            state_q <= sac_pkg::SAC_ACQ;
            acq_cnt_q <= ctrl1_q[`SAC_C1_ACQ_HI:`SAC_C1_ACQ_LO];
          end
        end
        sac_pkg::SAC_ACQ: begin
          if (tick) begin
            if (acq_cnt_q == 2'h0) begin
              state_q <= sac_pkg::SAC_CONV;
              bit_q <= `SAC_SAR_BITS - 4'h1;
              sar_q <= 12'h800;
            end else begin
              acq_cnt_q <= acq_cnt_q - 2'h1;
            end
          end
        end
        sac_pkg::SAC_CONV: begin
          // binary search, msb first; result is straight binary of vin/vref
          if (tick) begin
            if (!i_cmp_above) begin
              sar_q[bit_q] <= 1'b0;
            end
            if (bit_q != 4'h0) begin
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end else if (ctrl2_q[`SAC_C2_CONT]) begin
              state_q <= sac_pkg::SAC_ACQ;
              acq_cnt_q <= ctrl1_q[`SAC_C1_ACQ_HI:`SAC_C1_ACQ_LO];
            end else begin
              state_q <= sac_pkg::SAC_IDLE;
            end
          end
        end
        sac_pkg::SAC_CAL: begin
          if (tick) begin
            if (cal_cnt_q == 5'h00) begin
              state_q <= sac_pkg::SAC_IDLE;
            end else begin
              cal_cnt_q <= cal_cnt_q - 5'h01;
            end
          end
        end
        default: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  // busy covers acquisition, conversion and calibration
  // it follows the state one cycle late, so a read just after a start sees it clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == sac_pkg::SAC_ACQ) || (state_q == sac_pkg::SAC_CONV)
        || (state_q == sac_pkg::SAC_CAL);
    end
  end

  // ----------------------------------------------------------------------
  // calibration coefficients
  // ----------------------------------------------------------------------
  // the calibration measures the comparator by a simple tally of its answers
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      offset_q <= `SAC_FACT_OFFSET;
      gain_q <= `SAC_FACT_GAIN;
      cal_acc_q <= 12'h000;
    end else if (state_q == sac_pkg::SAC_IDLE) begin
      cal_acc_q <= 12'h000;
    end else if ((state_q == sac_pkg::SAC_CAL) && tick) begin
      cal_acc_q <= cal_acc_q + {4'h0, i_cmp_above, 7'h00};
      if (cal_done) begin
        if (ctrl3_q[`SAC_C3_TYPECAL]) begin
          gain_q <= cal_acc_q;
        end else begin
          offset_q <= cal_acc_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // result word
  // ----------------------------------------------------------------------
  // the last trial bit is settled by the comparator at the final tick
  assign final_code = {sar_q[11:1], sar_q[0] & i_cmp_above};
  // offset correction only: gain trimming is left to the analog core
  assign corrected = final_code - offset_q + `SAC_FACT_OFFSET;
  assign res_d = '{chan: chan_q, code: corrected};

  // ----------------------------------------------------------------------
  // result and spi capture
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_lo_q <= 8'h00;
      res_hi_q <= 8'h00;
      o_spi_word <= 16'h0000;
      o_spi_valid <= 1'b0;
    end else begin
      o_spi_valid <= 1'b0;
      if (conv_done) begin
        // both bytes written together so a read never mixes conversions
        res_lo_q <= res_d.code[7:0];
        res_hi_q <= {res_d.chan, res_d.code[11:8]};
        if (ctrl2_q[`SAC_C2_SPI_EN]) begin
          o_spi_word <= res_d;
          o_spi_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // analog front end drive
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_afe <= '0;
      o_dac_route_four <= 1'b0;
      o_dac_route_five <= 1'b0;
    end else begin
      o_afe.chan <= chan_q;
      o_afe.ext_ref <= ctrl1_q[`SAC_C1_EXTREF];
      o_afe.sample <= (state_q == sac_pkg::SAC_ACQ);
      o_afe.trial <= sar_q;
      o_dac_route_four <= i_analog_output_zero_en && (chan_q == 4'h4);
      o_dac_route_five <= i_analog_output_one_en && (chan_q == 4'h5);
    end
  end

  // ----------------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl1_q <= `SAC_CTRL_RST;
      ctrl2_q <= `SAC_CTRL_RST;
      ctrl3_q <= `SAC_CTRL_RST;
      chan_q <= 4'h0;
    end else begin
      if (wr_hit(i_paddr, `SAC_OFF_CTRL1, wr_en)) begin
        ctrl1_q <= i_pwdata[7:0];
      end
      if (wr_hit(i_paddr, `SAC_OFF_CTRL2, wr_en)) begin
        ctrl2_q <= {i_pwdata[7:4], 4'h0};
        chan_q <= i_pwdata[3:0];
      end else if (conv_start) begin
        ctrl2_q[`SAC_C2_SINGLE] <= 1'b0; // single start consumed
      end
      if (wr_hit(i_paddr, `SAC_OFF_CTRL3, wr_en)) begin
        ctrl3_q <= {1'b0, i_pwdata[6:0]};
      end else if (cal_done) begin
        ctrl3_q[`SAC_C3_START_CALIBRATION_BIT] <= 1'b0;
      end
    end
  end

  // reads answer in the access phase, zero wait states
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (rd_en) begin
        case (i_paddr)
          `SAC_OFF_CTRL1: o_prdata <= {24'h000000, ctrl1_q};
          `SAC_OFF_CTRL2: o_prdata <= {24'h000000, ctrl2_q[7:4], chan_q};
          `SAC_OFF_CTRL3: o_prdata <= {24'h000000, busy_q, ctrl3_q[6:0]};
          `SAC_OFF_RES_LO: o_prdata <= {24'h000000, res_lo_q};
          `SAC_OFF_RES_HI: o_prdata <= {24'h000000, res_hi_q};
          `SAC_OFF_OFFSET: o_prdata <= {20'h00000, offset_q};
          `SAC_OFF_GAIN: o_prdata <= {20'h00000, gain_q};
          default: begin
            o_prdata <= 32'h00000000;
          end
        endcase
      end
      if (i_psel && !i_penable) begin
        o_pslverr <= (i_paddr > `SAC_OFF_GAIN) || (i_paddr[1:0] != 2'h0);
      end
    end
  end

endmodule
`default_nettype wire

/* File: verilog/sac_pkg.sv */
/*
  types shared by the converter control block.
  assumes sac_regs.svh provides the numeric constants.
*/
`default_nettype none
package sac_pkg;

  typedef enum logic [4:0] {
    SAC_IDLE = 5'b00001,
    SAC_LOAD = 5'b00010,
    SAC_ACQ = 5'b00100,
    SAC_CONV = 5'b01000,
    SAC_CAL = 5'b10000
  } sac_state_t;

  // analog core handshake toward the comparator
  typedef struct packed {
    logic [3:0] chan;
    logic ext_ref;
    logic sample;
    logic [11:0] trial;
  } sac_afe_t;

  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] code;
  } sac_result_t;

endpackage
`default_nettype wire

/* File: verilog/sac_regs.svh */
/*
  register offsets, field positions, reset values and timing counts of the
  converter control block. assumes a 32-bit apb with word-aligned registers.
*/
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define SAC_OFF_CTRL1 12'h000
`define SAC_OFF_CTRL2 12'h004
`define SAC_OFF_CTRL3 12'h008
`define SAC_OFF_RES_LO 12'h00C
`define SAC_OFF_RES_HI 12'h010
`define SAC_OFF_OFFSET 12'h014
`define SAC_OFF_GAIN 12'h018

// ----------------------------------------------------------------------
// control 1 fields
// ----------------------------------------------------------------------
`define SAC_C1_EXTREF 6
`define SAC_C1_CLKDIV_HI 5
`define SAC_C1_CLKDIV_LO 4
`define SAC_C1_ACQ_HI 3
`define SAC_C1_ACQ_LO 2
`define SAC_C1_EXTTRIG 1
`define SAC_C1_TMRTRIG 0

// ----------------------------------------------------------------------
// control 2 fields
// ----------------------------------------------------------------------
`define SAC_C2_SPI_EN 7
`define SAC_C2_SINGLE 5
`define SAC_C2_CONT 4

// ----------------------------------------------------------------------
// control 3 fields
// ----------------------------------------------------------------------
`define SAC_C3_BUSY 7
`define SAC_C3_TYPECAL 1
`define SAC_C3_START_CALIBRATION_BIT 0

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define SAC_CTRL_RST 8'h00
`define SAC_FACT_OFFSET 12'h800
`define SAC_FACT_GAIN 12'h800
`define SAC_SAR_BITS 4'hC
`define SAC_CAL_STEPS 5'h10

`endif
